// *** design/ntb_hot_reset_handler.sv ***
`timescale 1ns/100ps
module ntb_hot_reset_handler
  import ntb_hot_reset_pkg::*;
#(
  parameter int PULSE_CYCLES = RST_OUT_CYCLES,
  parameter int HOLD_CYCLES  = SIDE_RESET_CYCLES
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        up_hot_reset_ts1,
  input  wire logic        up_dl_down,
  input  wire logic        ext_hot_reset_ts1,
  output logic             int_side_logic_reset,
  output logic             ext_side_logic_reset,
  output logic             int_not_ready,
  output logic             ext_not_ready,
  output logic             intx_assert,
  output logic             msi_request,
  output logic             bridge_port_reset_out_n,
  output logic             bridge_port_reset_oe
);

  localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CYCLES);
  localparam logic [7:0] HOLD_LOAD  = 8'(HOLD_CYCLES);

  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic        acc_wr;
  logic        ts1_up_q;
  logic        dl_down_q;
  logic        ts1_ext_q;
  logic        int_trig;
  logic        ext_trig;
  logic [7:0]  int_cnt_reg;
  logic [7:0]  ext_cnt_reg;
  logic [7:0]  pulse_cnt_reg;
  logic [2:0]  int_ctrl_reg;
  logic [2:0]  ext_ctrl_reg;
  logic [1:0]  irq_sel_reg;
  logic [1:0]  sw_ctrl_reg;
  logic        int_osr_reg;
  logic        int_oshr_reg;
  logic        ext_osr_reg;
  logic        ext_oshr_reg;
  logic        int_nr_reg;
  logic        ext_nr_reg;
  logic        intx_reg;
  logic        msi_reg;
  logic        rst_out_n_reg;
  logic        oe_reg;
  logic        int_busy;
  logic [2:0]  ext_ctrl_view;

  // bus handshake: waitrequest drops for one cycle after a request is seen
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wait_reg <= 1'b1;
    else
      wait_reg <= !((avs_read || avs_write) && wait_reg);
  end

  assign acc_wr   = avs_write && !wait_reg;
  assign int_busy = int_cnt_reg != 8'h00;

  // triggers from the link logic, same clock, taken on rising edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ts1_up_q  <= 1'b0;
      dl_down_q <= 1'b0;
      ts1_ext_q <= 1'b0;
    end
    else
    begin
      ts1_up_q  <= up_hot_reset_ts1;
      dl_down_q <= up_dl_down;
      ts1_ext_q <= ext_hot_reset_ts1;
    end
  end

  assign int_trig = (up_hot_reset_ts1 && !ts1_up_q)
                 || (up_dl_down && !dl_down_q)
                 || (acc_wr && avs_address == OFS_BRIDGE_PORT_CTRL
                     && avs_writedata[BIT_BRIDGE_RST_REQ])
                 || (acc_wr && avs_address == OFS_UP_BRIDGE_CTRL
                     && avs_writedata[BIT_SEC_BUS_RESET]);
  // the internal reset covers the external side, so an external one is moot then
  assign ext_trig = ext_hot_reset_ts1 && !ts1_ext_q && !int_trig && !int_busy;

  // side reset hold counters
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_cnt_reg <= 8'h00;
      ext_cnt_reg <= 8'h00;
    end
    else
    begin
      if (int_trig)
        int_cnt_reg <= HOLD_LOAD;
      else if (int_busy)
        int_cnt_reg <= int_cnt_reg - 8'h01;
      if (int_trig || ext_trig)
        ext_cnt_reg <= HOLD_LOAD;
      else if (ext_cnt_reg != 8'h00)
        ext_cnt_reg <= ext_cnt_reg - 8'h01;
    end
  end

  // side reset outputs; the external one leaves the internal side alone
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_side_logic_reset <= 1'b0;
      ext_side_logic_reset <= 1'b0;
    end
    else
    begin
      int_side_logic_reset <= int_trig || int_cnt_reg > 8'h01;
      ext_side_logic_reset <= int_trig || ext_trig || ext_cnt_reg > 8'h01;
    end
  end

  // ordinary control fields go back to initial values on side resets
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_ctrl_reg <= RST_SIDE_CTRL;
      ext_ctrl_reg <= RST_SIDE_CTRL;
      irq_sel_reg  <= RST_INT_CTRL;
      sw_ctrl_reg  <= RST_SWITCH_CTRL;
    end
    else if (int_trig)
    begin
      int_ctrl_reg <= RST_SIDE_CTRL;
      ext_ctrl_reg <= RST_SIDE_CTRL;
      irq_sel_reg  <= RST_INT_CTRL;
      sw_ctrl_reg  <= RST_SWITCH_CTRL;
    end
    else
    begin
      if (ext_trig)
        ext_ctrl_reg <= RST_SIDE_CTRL;
      else if (acc_wr && avs_address == OFS_EXT_BRIDGE_CTRL && !int_busy)
        ext_ctrl_reg <= avs_writedata[2:0];
      if (acc_wr && avs_address == OFS_INT_BRIDGE_CTRL)
        int_ctrl_reg <= avs_writedata[2:0];
      if (acc_wr && avs_address == OFS_INT_INT_CTRL)
        irq_sel_reg <= avs_writedata[1:0];
      if (acc_wr && avs_address == OFS_UP_SWITCH_CTRL)
        sw_ctrl_reg <= avs_writedata[1:0];
    end
  end

  // opposite side flags: kept over hot resets, write one clears, set wins
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_osr_reg  <= 1'b0;
      int_oshr_reg <= 1'b0;
      ext_osr_reg  <= 1'b0;
      ext_oshr_reg <= 1'b0;
    end
    else
    begin
      if (ext_trig)
        int_osr_reg <= 1'b1;
      else if (acc_wr && avs_address == OFS_INT_INT_STATUS && avs_writedata[BIT_OPP_FLAG])
        int_osr_reg <= 1'b0;
      if (ext_trig)
        int_oshr_reg <= 1'b1;
      else if (acc_wr && avs_address == OFS_INT_BRIDGE_STAT && avs_writedata[BIT_OPP_FLAG])
        int_oshr_reg <= 1'b0;
      if (int_trig)
        ext_osr_reg <= 1'b1;
      else if (acc_wr && avs_address == OFS_EXT_INT_STATUS && avs_writedata[BIT_OPP_FLAG])
        ext_osr_reg <= 1'b0;
      if (int_trig)
        ext_oshr_reg <= 1'b1;
      else if (acc_wr && avs_address == OFS_EXT_BRIDGE_STAT && avs_writedata[BIT_OPP_FLAG])
        ext_oshr_reg <= 1'b0;
    end
  end

  // not-ready response after an external hot reset; software clears it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_nr_reg <= 1'b0;
      ext_nr_reg <= 1'b0;
    end
    else
    begin
      if (ext_trig && int_ctrl_reg[BIT_RESET_ACT_EN]
          && (int_ctrl_reg[2:1] == RESP_INT_HOLD || int_ctrl_reg[2:1] == RESP_BOTH))
        int_nr_reg <= 1'b1;
      else if (acc_wr && avs_address == OFS_SIDE_STATE && avs_writedata[0])
        int_nr_reg <= 1'b0;
      if (ext_trig && int_ctrl_reg[BIT_RESET_ACT_EN]
          && (int_ctrl_reg[2:1] == RESP_EXT_HOLD || int_ctrl_reg[2:1] == RESP_BOTH))
        ext_nr_reg <= 1'b1;
      else if (acc_wr && avs_address == OFS_SIDE_STATE && avs_writedata[1])
        ext_nr_reg <= 1'b0;
    end
  end

  // interrupt toward the internal root: level for INTx, one pulse for MSI
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intx_reg <= 1'b0;
      msi_reg  <= 1'b0;
    end
    else
    begin
      intx_reg <= (int_osr_reg || ext_trig) && irq_sel_reg == IRQ_SEL_INTX;
      msi_reg  <= ext_trig && irq_sel_reg == IRQ_SEL_MSI;
    end
  end

  // downstream reset pulse counter on the core clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pulse_cnt_reg <= 8'h00;
    else if (int_trig || (ext_trig && sw_ctrl_reg[BIT_OUT_SEL_EXT]))
      pulse_cnt_reg <= PULSE_LOAD;
    else if (pulse_cnt_reg != 8'h00)
      pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
  end

  // reset pin: low while the count runs; enable follows the alternate function bit
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_out_n_reg <= 1'b1;
      oe_reg        <= 1'b0;
    end
    else
    begin
      rst_out_n_reg <= !(int_trig || (ext_trig && sw_ctrl_reg[BIT_OUT_SEL_EXT])
                         || pulse_cnt_reg > 8'h01);
      oe_reg        <= !int_trig && sw_ctrl_reg[BIT_GPIO1_ALT_EN];
    end
  end

  // external reset action fields read zero while the internal reset runs
  assign ext_ctrl_view = int_busy ? 3'h0 : ext_ctrl_reg;

  // read data registered when waitrequest drops; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read && wait_reg)
    begin
      unique case (avs_address)
        OFS_INT_BRIDGE_CTRL: rdata_reg <= {29'h0, int_ctrl_reg};
        OFS_EXT_BRIDGE_CTRL: rdata_reg <= {29'h0, ext_ctrl_view};
        OFS_INT_INT_STATUS:  rdata_reg <= {31'h0, int_osr_reg};
        OFS_INT_INT_CTRL:    rdata_reg <= {30'h0, irq_sel_reg};
        OFS_INT_BRIDGE_STAT: rdata_reg <= {31'h0, int_oshr_reg};
        OFS_EXT_INT_STATUS:  rdata_reg <= {31'h0, ext_osr_reg};
        OFS_EXT_BRIDGE_STAT: rdata_reg <= {31'h0, ext_oshr_reg};
        OFS_UP_SWITCH_CTRL:  rdata_reg <= {30'h0, sw_ctrl_reg};
        OFS_SIDE_STATE:      rdata_reg <= {27'h0, pulse_cnt_reg != 8'h00,
                                           ext_cnt_reg != 8'h00, int_busy,
                                           ext_nr_reg, int_nr_reg};
        default:             rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // outputs straight from flops
  assign avs_readdata            = rdata_reg;
  assign avs_waitrequest         = wait_reg;
  assign int_not_ready           = int_nr_reg;
  assign ext_not_ready           = ext_nr_reg;
  assign intx_assert             = intx_reg;
  assign msi_request             = msi_reg;
  assign bridge_port_reset_out_n = rst_out_n_reg;
  assign bridge_port_reset_oe    = oe_reg;

  // checks
  AST_DLDOWN_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(up_dl_down) |=> int_side_logic_reset && ext_side_logic_reset)
    else $error("link down did not start internal reset");

  AST_TS1_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(up_hot_reset_ts1) |=> int_side_logic_reset [*8])
    else $error("upstream hot reset too short");

  AST_EXT_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_trig && !int_busy |=> ext_side_logic_reset && !int_side_logic_reset)
    else $error("external reset touched internal side");

  AST_PULSE_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    int_trig |=> !bridge_port_reset_out_n [*8] ##(PULSE_CYCLES - 7) bridge_port_reset_out_n)
    else $error("reset output pulse width wrong");

  AST_PULSE_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_trig && !sw_ctrl_reg[BIT_OUT_SEL_EXT] && pulse_cnt_reg == 8'h00
    |=> bridge_port_reset_out_n)
    else $error("reset output pulsed without external select");

  AST_EXT_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_trig |=> int_osr_reg && int_oshr_reg)
    else $error("internal opposite flags not set");

  AST_INT_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    int_trig |=> ext_osr_reg && ext_oshr_reg && !bridge_port_reset_oe)
    else $error("external opposite flags not set");

  AST_MSI: assert property (@(posedge clk_sys) disable iff (!rst_n)
    msi_request |-> $past(irq_sel_reg) == IRQ_SEL_MSI && int_osr_reg ##1 !msi_request)
    else $error("msi without cause");

  AST_ZERO_VIEW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_read && wait_reg && avs_address == OFS_EXT_BRIDGE_CTRL && int_busy
    |=> avs_readdata == 32'h0000_0000)
    else $error("external action bits visible during internal reset");

  AST_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");

  COV_INT_RESET: cover property (@(posedge clk_sys) disable iff (!rst_n)
    int_trig ##[1:40] bridge_port_reset_out_n);
  COV_EXT_PULSE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ext_trig && sw_ctrl_reg[BIT_OUT_SEL_EXT]);
  COV_NOT_READY: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(int_not_ready) && $rose(ext_not_ready));

endmodule : ntb_hot_reset_handler

// *** design/ntb_hot_reset_pkg.sv ***
package ntb_hot_reset_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_UP_BRIDGE_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BRIDGE_PORT_CTRL = 8'h04;
  localparam logic [7:0] OFS_INT_BRIDGE_CTRL  = 8'h08;
  localparam logic [7:0] OFS_EXT_BRIDGE_CTRL  = 8'h0C;
  localparam logic [7:0] OFS_INT_INT_STATUS   = 8'h10;
  localparam logic [7:0] OFS_INT_INT_CTRL     = 8'h14;
  localparam logic [7:0] OFS_INT_BRIDGE_STAT  = 8'h18;
  localparam logic [7:0] OFS_EXT_INT_STATUS   = 8'h1C;
  localparam logic [7:0] OFS_EXT_BRIDGE_STAT  = 8'h20;
  localparam logic [7:0] OFS_UP_SWITCH_CTRL   = 8'h24;
  localparam logic [7:0] OFS_SIDE_STATE       = 8'h28;

  // field positions
  localparam int BIT_SEC_BUS_RESET  = 6;  // in upstream bridge control
  localparam int BIT_BRIDGE_RST_REQ = 0;  // in bridge port control
  localparam int BIT_RESET_ACT_EN   = 0;  // in side bridge control
  localparam int POS_RESET_RESPONSE = 1;  // two bits, side bridge control
  localparam int BIT_OPP_FLAG       = 0;  // in status registers
  localparam int BIT_OUT_SEL_EXT    = 0;  // in upstream switch control
  localparam int BIT_GPIO1_ALT_EN   = 1;  // in upstream switch control

  // reset values of software fields
  localparam logic [2:0] RST_SIDE_CTRL   = 3'h0;
  localparam logic [1:0] RST_INT_CTRL    = 2'h0;
  localparam logic [1:0] RST_SWITCH_CTRL = 2'h0;

  // opposite side reset response
  localparam logic [1:0] RESP_NONE     = 2'h0;
  localparam logic [1:0] RESP_INT_HOLD = 2'h1;
  localparam logic [1:0] RESP_EXT_HOLD = 2'h2;
  localparam logic [1:0] RESP_BOTH     = 2'h3;

  // interrupt selection
  localparam logic [1:0] IRQ_SEL_NONE = 2'h0;
  localparam logic [1:0] IRQ_SEL_INTX = 2'h1;
  localparam logic [1:0] IRQ_SEL_MSI  = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int RST_OUT_TIME_NS   = 250;
  localparam int RST_OUT_CYCLES    = (RST_OUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SIDE_RESET_CYCLES = 16;

endpackage : ntb_hot_reset_pkg

// *** verification/ntb_link_partner.sv ***
`timescale 1ns/100ps
// far side link logic: turns a one-cycle request into a trigger level
module ntb_link_partner
#(
  parameter int TS1_CYCLES = 4
)(
  clk_sys,
  rst_n,
  req,
  up_hot_reset_ts1,
  up_dl_down,
  ext_hot_reset_ts1
);
  input  wire logic       clk_sys;
  input  wire logic       rst_n;
  input  wire logic [2:0] req;
  output logic            up_hot_reset_ts1;
  output logic            up_dl_down;
  output logic            ext_hot_reset_ts1;

  logic [2:0] line_reg;
  int         cnt_reg [3];

  // each line held high for a burst of ordered sets, then low again
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    for (int k = 0; k < 3; k++)
      if (!rst_n)
      begin
        line_reg[k] <= 1'b0;
        cnt_reg[k]  <= 0;
      end
      else if (req[k])
      begin
        line_reg[k] <= 1'b1;
        cnt_reg[k]  <= TS1_CYCLES;
      end
      else if (cnt_reg[k] > 1)
        cnt_reg[k] <= cnt_reg[k] - 1;
      else
      begin
        line_reg[k] <= 1'b0;
        cnt_reg[k]  <= 0;
      end
  end

  // upstream hot reset sets, link down, bridge port hot reset sets
  assign up_hot_reset_ts1  = line_reg[0];
  assign up_dl_down        = line_reg[1];
  assign ext_hot_reset_ts1 = line_reg[2];
endmodule : ntb_link_partner

// *** verification/tb_ntb_hot_reset_handler.sv ***
`timescale 1ns/100ps
module tb_ntb_hot_reset_handler
  import ntb_hot_reset_pkg::*;
;
  localparam int PULSE = RST_OUT_CYCLES;
  localparam int HOLD  = SIDE_RESET_CYCLES;

  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic        up_hot_reset_ts1, up_dl_down, ext_hot_reset_ts1;
  logic        int_side_logic_reset, ext_side_logic_reset, int_not_ready, ext_not_ready;
  logic        intx_assert, msi_request, bridge_port_reset_out_n, bridge_port_reset_oe;
  logic [2:0]  trig_req, mon;
  logic [1:0]  sel;
  logic [31:0] ctrl;
  int          error_cnt = 0;
  int          compares  = 0;
  int          run_len [3];
  int          last_len [3];
  int          msi_cnt;

  ntb_link_partner partner_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(trig_req),
    .up_hot_reset_ts1(up_hot_reset_ts1), .up_dl_down(up_dl_down),
    .ext_hot_reset_ts1(ext_hot_reset_ts1));

  ntb_hot_reset_handler #(.PULSE_CYCLES(PULSE), .HOLD_CYCLES(HOLD)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .up_hot_reset_ts1(up_hot_reset_ts1),
    .up_dl_down(up_dl_down), .ext_hot_reset_ts1(ext_hot_reset_ts1),
    .int_side_logic_reset(int_side_logic_reset), .ext_side_logic_reset(ext_side_logic_reset),
    .int_not_ready(int_not_ready), .ext_not_ready(ext_not_ready),
    .intx_assert(intx_assert), .msi_request(msi_request),
    .bridge_port_reset_out_n(bridge_port_reset_out_n),
    .bridge_port_reset_oe(bridge_port_reset_oe));

  // clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // run lengths of reset pulse and side resets, sampled mid cycle
  always @(negedge clk_sys)
  begin
    mon = {~bridge_port_reset_out_n, int_side_logic_reset, ext_side_logic_reset};
    for (int k = 0; k < 3; k++)
      if (mon[k] === 1'b1)
        run_len[k]++;
      else if (run_len[k] != 0)
      begin
        last_len[k] = run_len[k];
        run_len[k]  = 0;
      end
    if (msi_request === 1'b1)
      msi_cnt++;
  end

  task automatic conclude;
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one bus access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : av

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    av(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rd_chk

  task automatic setup(input logic [31:0] sw, input logic [31:0] ic, input logic [1:0] s);
    av(1'b1, OFS_UP_SWITCH_CTRL, sw);
    av(1'b1, OFS_EXT_BRIDGE_CTRL, 32'h7);
    av(1'b1, OFS_INT_BRIDGE_CTRL, ic);
    av(1'b1, OFS_INT_INT_CTRL, {30'h0, s});
    av(1'b1, OFS_SIDE_STATE, 32'h3);
    for (int k = 0; k < 3; k++)
      last_len[k] = 0;
    msi_cnt = 0;
  endtask : setup

  task automatic pulse(input int k);
    @(posedge clk_sys);
    trig_req[k] <= 1'b1;
    @(posedge clk_sys);
    trig_req <= 3'h0;
  endtask : pulse

  // watchdog
  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end

  initial
  begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, trig_req} = '0;
    msi_cnt = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    check({31'h0, bridge_port_reset_out_n}, 32'h1);
    rd_chk(8'h30, 32'h0);
    rd_chk(OFS_INT_BRIDGE_CTRL, 32'h0);
    // internal hot reset from each of its four sources
    for (int i = 0; i < 4; i++)
    begin
      setup(32'h3, 32'h7, IRQ_SEL_INTX);
      check({31'h0, bridge_port_reset_oe}, 32'h1);
      case (i)
        0: pulse(0);
        1: pulse(1);
        2: av(1'b1, OFS_BRIDGE_PORT_CTRL, 32'h1);
        default: av(1'b1, OFS_UP_BRIDGE_CTRL, 32'h40);
      endcase
      repeat (4) @(posedge clk_sys);
      #1;
      check({30'h0, int_side_logic_reset, ext_side_logic_reset}, 32'h3);
      av(1'b1, OFS_EXT_BRIDGE_CTRL, 32'h7);
      rd_chk(OFS_EXT_BRIDGE_CTRL, 32'h0);
      repeat (40) @(posedge clk_sys);
      check(last_len[2], PULSE);
      check(last_len[1], HOLD);
      check(last_len[0], HOLD);
      rd_chk(OFS_EXT_BRIDGE_CTRL, 32'h0);
      rd_chk(OFS_EXT_INT_STATUS, 32'h1);
      rd_chk(OFS_EXT_BRIDGE_STAT, 32'h1);
      rd_chk(OFS_INT_BRIDGE_CTRL, 32'h0);
      rd_chk(OFS_INT_INT_CTRL, 32'h0);
      rd_chk(OFS_UP_SWITCH_CTRL, 32'h0);
      check({31'h0, bridge_port_reset_oe}, 32'h0);
      av(1'b1, OFS_EXT_INT_STATUS, 32'h1);
      av(1'b1, OFS_EXT_BRIDGE_STAT, 32'h1);
      rd_chk(OFS_EXT_INT_STATUS, 32'h0);
    end
    // external hot reset over response codes 1 to 3, code 3 also with the action disabled, and every interrupt selection
    for (int r = 0; r < 4; r++)
    begin
      sel  = (r == 1) ? IRQ_SEL_INTX : (r == 2) ? IRQ_SEL_MSI : IRQ_SEL_NONE;
      ctrl = (r == 0) ? 32'h6 : {29'h0, 2'(r), 1'b1};
      setup({30'h0, 1'b1, r[0]}, ctrl, sel);
      pulse(2);
      repeat (40) @(posedge clk_sys);
      check(last_len[1], 32'h0);
      check(last_len[0], HOLD);
      check(last_len[2], r[0] ? PULSE : 0);
      check({30'h0, ext_not_ready, int_not_ready}, 32'(r));
      check(msi_cnt, (sel == IRQ_SEL_MSI) ? 32'h1 : 32'h0);
      check({31'h0, intx_assert}, {31'h0, sel == IRQ_SEL_INTX});
      rd_chk(OFS_INT_INT_STATUS, 32'h1);
      rd_chk(OFS_INT_BRIDGE_STAT, 32'h1);
      rd_chk(OFS_EXT_BRIDGE_CTRL, 32'h0);
      rd_chk(OFS_INT_BRIDGE_CTRL, ctrl);
      rd_chk(OFS_UP_SWITCH_CTRL, {30'h0, 1'b1, r[0]});
      av(1'b1, OFS_INT_INT_STATUS, 32'h1);
      av(1'b1, OFS_INT_BRIDGE_STAT, 32'h1);
      repeat (2) @(posedge clk_sys);
      check({31'h0, intx_assert}, 32'h0);
    end
    conclude();
  end
endmodule : tb_ntb_hot_reset_handler
